// [hw/uhs_status_frame_regs.sv]
// interrupt status, enable mask, frame counter, frame list base and frame adjust
`timescale 1ns/10ps
`include "uhs_map.svh"

module uhs_status_frame_regs (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESET,
  input  wire logic                 HC_RESET,
  // i/o register port
  input  wire logic                 IO_WR,
  input  wire logic                 IO_RD,
  input  wire logic [2:0]           IO_DW,
  input  wire logic [3:0]           IO_BE,
  input  wire logic [31:0]          IO_WDATA,
  output logic      [31:0]          IO_RDATA,
  // command and controller state
  input  wire logic                 RUN_STOP,
  input  wire logic                 SUSPEND,
  input  wire logic                 HALTED,
  // events
  input  wire logic                 PCI_ABORT,
  input  wire logic                 PROC_ERR,
  input  wire logic                 RESUME_SEEN,
  input  wire uhs_pkg::uhs_td_evt_t TD_EVT,
  input  wire logic                 SOF_TICK,
  // outputs to the controller and system
  output logic                      IRQ,
  output logic                      RS_CLEAR,
  output logic                      SYS_RESET,
  output logic                      SOF_PULSE,
  output logic      [10:0]          FRAME_NUM,
  output logic      [31:0]          FL_ADDR
);

  uhs_pkg::uhs_io_req_t req;
  logic [4:0]  sts_q;
  logic [4:0]  sts_set;
  logic [4:0]  sts_clr;
  logic        cause_ioc_q;
  logic        cause_short_q;
  logic        set_ioc;
  logic        set_short;
  logic [3:0]  ena_q;
  logic [10:0] frame_q;
  logic [19:0] flbase_q;
  logic [6:0]  adj_q;
  logic        frame_end;
  logic        irq_d;
  logic        wr_sts;
  logic        wr_ena;
  logic        wr_frame;
  logic        wr_base;
  logic        wr_adj;

  assign req = '{wr: IO_WR, rd: IO_RD, dw: IO_DW, be: IO_BE, wdata: IO_WDATA};

  // write strobes per register; frame counter needs both upper lanes
  assign wr_sts   = req.wr && req.dw == `UHS_DW_STATUS && req.be[2];
  assign wr_ena   = req.wr && req.dw == `UHS_DW_ENA_FRAME && req.be[0];
  assign wr_frame = req.wr && req.dw == `UHS_DW_ENA_FRAME && (&req.be[3:2]);
  assign wr_base  = req.wr && req.dw == `UHS_DW_FLBASE;
  assign wr_adj   = req.wr && req.dw == `UHS_DW_FRAME_ADJ && req.be[0];

  // hardware set terms for each sticky flag
  assign set_ioc   = TD_EVT.done && TD_EVT.interrupt_on_completion;
  assign set_short = TD_EVT.done && TD_EVT.shrt;
  always_comb begin
    sts_set                    = '0;
    sts_set[`UHS_STS_DONE]     = set_ioc || set_short;
    sts_set[`UHS_STS_ERR]      = TD_EVT.done && TD_EVT.err;
    sts_set[`UHS_STS_RESUME]   = RESUME_SEEN && SUSPEND;
    sts_set[`UHS_STS_PCI_ERR]  = PCI_ABORT;
    sts_set[`UHS_STS_PROC_ERR] = PROC_ERR;
  end

  // status lives in lane 2 of dword 0 (byte offset 2)
  assign sts_clr = wr_sts ? req.wdata[20:16] : 5'h00;

  // sticky flags: a set in the same cycle as its clear wins
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      sts_q <= 5'h00;
    end else if (HC_RESET) begin
      sts_q <= 5'h00;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
    end
  end

  // remember why bit0 is up, the two causes have separate enables
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cause_ioc_q   <= 1'b0;
      cause_short_q <= 1'b0;
    end else if (HC_RESET) begin
      cause_ioc_q   <= 1'b0;
      cause_short_q <= 1'b0;
    end else begin
      cause_ioc_q   <= (cause_ioc_q & ~sts_clr[`UHS_STS_DONE]) | set_ioc;
      cause_short_q <= (cause_short_q & ~sts_clr[`UHS_STS_DONE]) | set_short;
    end
  end

  // enable mask, bits 15:4 not stored
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      ena_q <= `UHS_ENA_RESET;
    end else if (HC_RESET) begin
      ena_q <= `UHS_ENA_RESET;
    end else if (wr_ena) begin
      ena_q <= req.wdata[3:0];
    end
  end

  // frame counter: software load only when stopped, else count frames
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      frame_q <= `UHS_FRAME_RESET;
    end else if (HC_RESET) begin
      frame_q <= `UHS_FRAME_RESET;
    end else if (wr_frame && !RUN_STOP) begin
      frame_q <= req.wdata[26:16];
    end else if (frame_end) begin
      frame_q <= frame_q + 11'h001;
    end
  end

  // base address, low 12 bits never stored so they read as zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      flbase_q <= `UHS_FLBASE_RESET;
    end else if (wr_base) begin
      if (req.be[1]) flbase_q[3:0]   <= req.wdata[15:12];
      if (req.be[2]) flbase_q[11:4]  <= req.wdata[23:16];
      if (req.be[3]) flbase_q[19:12] <= req.wdata[31:24];
    end
  end

  // adjust accepted at any time; a controller reset restores the default
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      adj_q <= `UHS_ADJ_RESET;
    end else if (HC_RESET) begin
      adj_q <= `UHS_ADJ_RESET;
    end else if (wr_adj) begin
      adj_q <= req.wdata[6:0];
    end
  end

  // frame period timer
  uhs_frame_timer #(
    .CW (14)
  ) u_timer (
    .clk       (CLK),
    .reset     (RESET),
    .run       (RUN_STOP),
    .tick      (SOF_TICK),
    .adj       (adj_q),
    .frame_end (frame_end)
  );

  // interrupt line; the fatal errors bypass the mask
  assign irq_d = (sts_q[`UHS_STS_ERR] && ena_q[`UHS_ENA_TIMEOUT])
              || (sts_q[`UHS_STS_RESUME] && ena_q[`UHS_ENA_RESUME])
              || (cause_ioc_q && ena_q[`UHS_ENA_IOC])
              || (cause_short_q && ena_q[`UHS_ENA_SHORT])
              || sts_q[`UHS_STS_PCI_ERR]
              || sts_q[`UHS_STS_PROC_ERR];

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_d;
    end
  end

  // fatal error handling: one-cycle pulses to the command logic and system
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RS_CLEAR  <= 1'b0;
      SYS_RESET <= 1'b0;
    end else begin
      RS_CLEAR  <= PCI_ABORT || PROC_ERR;
      SYS_RESET <= PCI_ABORT || PROC_ERR;
    end
  end

  // frame outputs, registered so the sof packet and fetch see stable values
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      SOF_PULSE <= 1'b0;
      FRAME_NUM <= `UHS_FRAME_RESET;
      FL_ADDR   <= 32'h0000_0000;
    end else begin
      SOF_PULSE <= frame_end;
      FRAME_NUM <= frame_q;
      FL_ADDR   <= {flbase_q, frame_q[9:0], 2'b00};
    end
  end

  // registered read data, one cycle after the read strobe
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IO_RDATA <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.dw)
        `UHS_DW_STATUS:    IO_RDATA <= {10'h000, HALTED, sts_q, 16'h0000};
        `UHS_DW_ENA_FRAME: IO_RDATA <= {5'h00, frame_q, 12'h000, ena_q};
        `UHS_DW_FLBASE:    IO_RDATA <= {flbase_q, 12'h000};
        `UHS_DW_FRAME_ADJ: IO_RDATA <= {25'h0000000, adj_q};
        default:           IO_RDATA <= 32'h0000_0000; // unmapped reads as zero
      endcase
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  pci_err_set_a: assert property (PCI_ABORT && !HC_RESET |=> sts_q[`UHS_STS_PCI_ERR])
    else $error("pci abort did not set status bit 3");
  pci_err_stop_a: assert property (PCI_ABORT |=> RS_CLEAR && SYS_RESET)
    else $error("pci abort did not stop run and reset system");
  resume_gate_a: assert property (
    RESUME_SEEN && !SUSPEND && !sts_q[`UHS_STS_RESUME] |=> !sts_q[`UHS_STS_RESUME])
    else $error("resume flagged while not suspended");
  err_ioc_both_a: assert property (
    TD_EVT.done && TD_EVT.err && TD_EVT.interrupt_on_completion && !HC_RESET |=> sts_q[1:0] == 2'b11)
    else $error("error with ioc did not set both flags");
  zero_write_keep_a: assert property (
    wr_sts && req.wdata[16] == 1'b0 && sts_q[0] && !HC_RESET |=> sts_q[0])
    else $error("writing zero cleared a flag");
  short_poll_a: assert property (
    set_short && !ena_q[`UHS_ENA_SHORT] && !HC_RESET |=> sts_q[`UHS_STS_DONE])
    else $error("masked short packet did not set flag");
  fatal_irq_a: assert property (sts_q[`UHS_STS_PROC_ERR] |=> IRQ)
    else $error("process error did not raise interrupt");
  enabled_irq_a: assert property (
    sts_q[`UHS_STS_RESUME] && ena_q[`UHS_ENA_RESUME] |=> IRQ)
    else $error("enabled resume did not raise interrupt");
  frame_lock_a: assert property (
    RUN_STOP && !frame_end && !HC_RESET |=> frame_q == $past(frame_q))
    else $error("frame counter changed while running without frame end");
  frame_step_a: assert property (
    frame_end && !HC_RESET && !(wr_frame && !RUN_STOP)
      |=> frame_q == $past(frame_q) + 11'h001)
    else $error("frame counter did not step at frame end");
  entry_addr_a: assert property (
    ##1 FL_ADDR == {$past(flbase_q), $past(frame_q[9:0]), 2'b00})
    else $error("frame list entry address malformed");
  adj_default_a: assert property (HC_RESET |=> adj_q == `UHS_ADJ_RESET)
    else $error("controller reset did not restore adjust default");

endmodule

// [hw/uhs_map.svh]
// register offsets, field positions, reset values and frame timing constants
`ifndef UHS_MAP_SVH
`define UHS_MAP_SVH

// dword indices of the i/o window (byte address = index * 4)
`define UHS_DW_STATUS      3'h0
`define UHS_DW_ENA_FRAME   3'h1
`define UHS_DW_FLBASE      3'h2
`define UHS_DW_FRAME_ADJ   3'h3

// byte offsets as seen by software
`define UHS_OFS_STATUS     5'h02
`define UHS_OFS_ENABLE     5'h04
`define UHS_OFS_FRAME      5'h06
`define UHS_OFS_FLBASE     5'h08
`define UHS_OFS_FRAME_ADJ  5'h0c

// status flag positions
`define UHS_STS_DONE       0
`define UHS_STS_ERR        1
`define UHS_STS_RESUME     2
`define UHS_STS_PCI_ERR    3
`define UHS_STS_PROC_ERR   4
`define UHS_STS_HALTED     5

// enable mask positions
`define UHS_ENA_TIMEOUT    0
`define UHS_ENA_RESUME     1
`define UHS_ENA_IOC        2
`define UHS_ENA_SHORT      3

// reset values
`define UHS_ENA_RESET      4'h0
`define UHS_FRAME_RESET    11'h000
`define UHS_FLBASE_RESET   20'h00000
`define UHS_ADJ_RESET      7'h40

// frame length in sof counter ticks is base plus the adjust value
`define UHS_SOF_BASE       14'h2ea0
`define UHS_SOF_HZ         12000000

`endif

// [hw/uhs_pkg.sv]
// shared types of the status and frame register block
package uhs_pkg;

  // completion report of one transfer descriptor
  typedef struct packed {
    logic done;   // descriptor finished
    logic err;    // finished with an error
    logic interrupt_on_completion;    // interrupt_on_completion was set
    logic shrt;   // short packet seen and enabled
  } uhs_td_evt_t;

  // one i/o request from the host bridge
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  dw;
    logic [3:0]  be;
    logic [31:0] wdata;
  } uhs_io_req_t;

endpackage

// [hw/uhs_frame_timer.sv]
// frame period timer driven by the 12 mhz sof counter tick
`timescale 1ns/10ps
`include "uhs_map.svh"

module uhs_frame_timer #(
  parameter int unsigned CW = 14
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          run,
  input  wire logic          tick,
  input  wire logic [6:0]    adj,
  output logic               frame_end
);

  logic [CW-1:0] count_q;
  logic [CW-1:0] len_q;
  logic [CW-1:0] len_d;

  assign len_d = CW'(`UHS_SOF_BASE) + CW'(adj);

  // length is latched at frame start so a new adjust only hits the next frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_q   <= '0;
      len_q     <= CW'(`UHS_SOF_BASE) + CW'(`UHS_ADJ_RESET);
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (!run) begin
        count_q <= '0;
        len_q   <= len_d;
      end else if (tick) begin
        if (count_q == len_q - CW'(1)) begin
          count_q   <= '0;
          len_q     <= len_d;
          frame_end <= 1'b1;
        end else begin
          count_q <= count_q + CW'(1);
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  count_bound_a: assert property (count_q < len_q)
    else $error("frame timer ran past the frame length");
  end_on_tick_a: assert property (frame_end |-> $past(tick) && $past(run))
    else $error("frame end without a sof tick");
  end_restart_a: assert property (frame_end |-> count_q == '0)
    else $error("counter not restarted at frame end");

endmodule

// [test/uhs_host_model.sv]
// host software model issuing i/o reads and writes to the register block
`timescale 1ns/10ps

module uhs_host_model (
  // clock
  input  wire logic        clk,
  // i/o port
  output logic             wr,
  output logic             rd,
  output logic [2:0]       dw,
  output logic [3:0]       be,
  output logic [31:0]      wdata,
  input  wire logic [31:0] rdata
);
  // idle bus at time zero
  initial begin
    wr    = 1'h0;
    rd    = 1'h0;
    dw    = 3'h0;
    be    = 4'h0;
    wdata = 32'h0;
  end

  // one-cycle strobe; data inverted afterwards so nothing leans on a stale bus
  task automatic io_write(input logic [2:0] d, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk);
    wr    <= 1'h1;
    dw    <= d;
    be    <= b;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'h0;
    wdata <= ~v;
  endtask

  // read data is registered at the taking edge and held until the next read
  task automatic io_read(input logic [2:0] d, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'h1;
    dw <= d;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdata;
  endtask

  // frame counter write of both upper lanes (byte enables 4'hc); the partial-lane case uses io_write
  task automatic frame_write(input logic [10:0] fn);
    io_write(3'h1, 4'hc, {5'h00, fn, 16'h0000});
  endtask
endmodule

// [test/uhs_status_frame_regs_tb.sv]
// self-checking bench for the status, enable and frame register block
`timescale 1ns/10ps

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end

module uhs_status_frame_regs_tb;
  typedef struct packed {
    logic [3:0]           ena;
    uhs_pkg::uhs_td_evt_t td;
    logic                 res;
    logic                 sus;
    logic                 pci;
    logic                 perr;
    logic [4:0]           sts;
    logic                 irq;
  } uhs_row_t;

  // enable, td event, resume/suspend/pci/proc, status, irq
  uhs_row_t rows [10] = '{
    {4'h4, 4'ha, 4'h0, 5'h01, 1'h1},
    {4'h8, 4'ha, 4'h0, 5'h01, 1'h0},
    {4'h8, 4'h9, 4'h0, 5'h01, 1'h1},
    {4'h1, 4'he, 4'h0, 5'h03, 1'h1},
    {4'h0, 4'hc, 4'h0, 5'h02, 1'h0},
    {4'hf, 4'h7, 4'h0, 5'h00, 1'h0},
    {4'h2, 4'h0, 4'hc, 5'h04, 1'h1},
    {4'h2, 4'h0, 4'h8, 5'h00, 1'h0},
    {4'h0, 4'h0, 4'h2, 5'h08, 1'h1},
    {4'h0, 4'h0, 4'h1, 5'h10, 1'h1}
  };

  logic                 clk, reset, hc_reset, run, sus, halted, pci, perr, res, tick, tick_en;
  uhs_pkg::uhs_td_evt_t td;
  logic                 io_wr, io_rd, irq, rs_clear, sys_rst, sof;
  logic [2:0]           io_dw;
  logic [3:0]           io_be;
  logic [31:0]          io_wdata, io_rdata, fl_addr, rd;
  logic [10:0]          frame_num;
  int                   failures = 0, n_compared = 0, ticks = 0, last_len = 0;

  uhs_host_model host (.clk(clk), .wr(io_wr), .rd(io_rd), .dw(io_dw), .be(io_be),
    .wdata(io_wdata), .rdata(io_rdata));

  uhs_status_frame_regs u_dut (.CLK(clk), .RESET(reset), .HC_RESET(hc_reset),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_DW(io_dw), .IO_BE(io_be), .IO_WDATA(io_wdata),
    .IO_RDATA(io_rdata), .RUN_STOP(run), .SUSPEND(sus), .HALTED(halted),
    .PCI_ABORT(pci), .PROC_ERR(perr), .RESUME_SEEN(res), .TD_EVT(td), .SOF_TICK(tick),
    .IRQ(irq), .RS_CLEAR(rs_clear), .SYS_RESET(sys_rst), .SOF_PULSE(sof),
    .FRAME_NUM(frame_num), .FL_ADDR(fl_addr));

  // 25 mhz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // sof tick every other cycle, roughly the 12 mhz rate
  always @(posedge clk) tick <= tick_en ? ~tick : 1'h0;

  // ticks between frame pulses, counting this edge's tick as well
  always @(posedge clk) begin
    if (sof) begin
      last_len <= ticks + tick;
      ticks    <= 0;
    end else begin
      ticks <= ticks + tick;
    end
  end

  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bounded wait for a frame pulse; sampled off the edge to avoid races
  task automatic wait_sof();
    for (int i = 0; i < 30000 && sof !== 1'h1; i++) @(negedge clk);
    if (sof !== 1'h1) begin
      failures++;
      conclude();
    end
    @(posedge clk);
    #1;
  endtask

  // one-cycle event pulses; suspend is left as a level
  task automatic pulse_row(input uhs_row_t r);
    @(posedge clk);
    td   <= r.td;
    res  <= r.res;
    sus  <= r.sus;
    pci  <= r.pci;
    perr <= r.perr;
    @(posedge clk);
    td   <= 4'h0;
    res  <= 1'h0;
    pci  <= 1'h0;
    perr <= 1'h0;
    #1;
  endtask

  initial begin
    {reset, hc_reset, run, sus, pci, perr, res, tick, tick_en} = 9'h100;
    halted = 1'h1;
    td     = 4'h0;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    host.io_read(3'h1, rd);
    `CHK(rd, 32'h0)
    host.io_read(3'h3, rd);
    `CHK(rd[7:0], 8'h40)
    foreach (rows[k]) begin
      host.io_write(3'h1, 4'h3, {28'h0, rows[k].ena});
      pulse_row(rows[k]);
      `CHK(rs_clear, rows[k].pci | rows[k].perr)
      `CHK(sys_rst, rows[k].pci | rows[k].perr)
      @(posedge clk);
      #1 `CHK(irq, rows[k].irq)
      host.io_read(3'h0, rd);
      `CHK(rd[20:16], rows[k].sts)
      `CHK(rd[21], 1'h1)
      host.io_write(3'h0, 4'h4, 32'h001f0000);
      host.io_read(3'h0, rd);
      `CHK({rd[20:16], irq}, 6'h00)
    end
    // zero bits keep a flag, a single one clears only its own
    pulse_row(rows[3]);
    host.io_write(3'h0, 4'h4, 32'h0);
    host.io_write(3'h0, 4'h4, 32'h00010000);
    host.io_read(3'h0, rd);
    `CHK(rd[20:16], 5'h02)
    host.io_write(3'h1, 4'h3, 32'h0000ffff);
    host.io_read(3'h1, rd);
    `CHK(rd[15:0], 16'h000f)
    // frame writes refused while running or with partial enables
    run <= 1'h1;
    host.frame_write(11'h7ff);
    run <= 1'h0;
    host.io_write(3'h1, 4'h4, 32'h07ff0000);
    host.io_read(3'h1, rd);
    `CHK(rd[31:16], 16'h0)
    host.frame_write(11'h7ff);
    host.io_write(3'h2, 4'hf, 32'h12345000);
    host.io_write(3'h3, 4'h1, 32'h000000ff);
    host.io_read(3'h1, rd);
    `CHK(rd[31:16], 16'h07ff)
    host.io_read(3'h2, rd);
    `CHK(rd, 32'h12345000)
    `CHK(fl_addr, 32'h12345ffc)
    host.io_read(3'h3, rd);
    `CHK(rd[7:0], 8'h7f)
    host.io_write(3'h3, 4'h1, 32'h0);
    // run three frames; adjust changed mid-frame applies from the next one
    run     <= 1'h1;
    halted  <= 1'h0;
    tick_en <= 1'h1;
    wait_sof();
    `CHK(frame_num, 11'h000)
    host.frame_write(11'h123);
    host.io_write(3'h3, 4'h1, 32'h0000007f);
    host.io_read(3'h3, rd);
    `CHK(rd[6:0], 7'h7f)
    wait_sof();
    `CHK(last_len, 11936)
    `CHK(frame_num, 11'h001)
    wait_sof();
    `CHK(last_len, 12063)
    `CHK(frame_num, 11'h002)
    run     <= 1'h0;
    halted  <= 1'h1;
    tick_en <= 1'h0;
    @(posedge clk);
    hc_reset <= 1'h1;
    @(posedge clk);
    hc_reset <= 1'h0;
    host.io_read(3'h3, rd);
    `CHK(rd[7:0], 8'h40)
    host.io_read(3'h1, rd);
    `CHK(rd, 32'h0)
    conclude();
  end
endmodule
